//--- design/decode_pkg.sv
// Shared constants and addressing-mode types for the instruction decoder
package decode_pkg;

  localparam logic [7:0] PFX_Y_SWAP = 8'h90;
  localparam logic [7:0] PFX_IND_Y = 8'h91;
  localparam logic [7:0] PFX_IND = 8'h92;
  localparam logic [7:0] PFX_NONE = 8'h00;

  localparam logic [15:0] BOOT_PC = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] LEN_STEP = 3'h1;
  localparam logic [2:0] LEN_NONE = 3'h0;
  localparam logic [1:0] BYTES_NONE = 2'h0;
  localparam logic [1:0] BYTES_ONE = 2'h1;
  localparam logic [1:0] BYTES_TWO = 2'h2;

  // Opcode map rows (upper nibble)
  localparam logic [3:0] ROW_BIT_REL = 4'h0;
  localparam logic [3:0] ROW_BIT = 4'h1;
  localparam logic [3:0] ROW_REL = 4'h2;
  localparam logic [3:0] ROW_DIR_RMW = 4'h3;
  localparam logic [3:0] ROW_IDXS_RMW = 4'h6;
  localparam logic [3:0] ROW_IDX0_RMW = 4'h7;
  localparam logic [3:0] ROW_IMM = 4'ha;
  localparam logic [3:0] ROW_DIR_S = 4'hb;
  localparam logic [3:0] ROW_DIR_L = 4'hc;
  localparam logic [3:0] ROW_IDX_L = 4'hd;
  localparam logic [3:0] ROW_IDX_S = 4'he;
  localparam logic [3:0] ROW_IDX0 = 4'hf;
  localparam logic [7:0] OP_REL_CALL = 8'had;
  localparam logic [7:0] OP_MUL = 8'h42;
  localparam logic [7:0] OP_BAD_IMM_ST = 8'ha7;
  localparam logic [7:0] OP_BAD_IMM_JP = 8'hac;
  localparam logic [3:0] COL_HOLE_A = 4'h1;
  localparam logic [3:0] COL_HOLE_B = 4'h2;
  localparam logic [3:0] COL_HOLE_C = 4'h5;
  localparam logic [3:0] COL_HOLE_D = 4'hb;

  typedef enum logic [4:0] {
    AM_INH, AM_IMM, AM_DIR_S, AM_DIR_L, AM_IDX0, AM_IDX_S, AM_IDX_L,
    AM_IND_S, AM_IND_L, AM_IIDX_S, AM_IIDX_L, AM_REL, AM_REL_IND,
    AM_BIT, AM_BIT_IND, AM_BIT_REL, AM_BIT_IND_REL
  } am_t;

  typedef struct packed {
    logic legal;
    am_t mode;
  } op_class_t;

endpackage

//--- design/opcode_mode_rom.sv
// Registered opcode table: base addressing mode and legality per opcode byte
`timescale 1ns/10ps
module opcode_mode_rom (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic rd_en,
  input wire logic [7:0] opcode,
  output decode_pkg::op_class_t class_out
);
  import decode_pkg::*;

  typedef struct packed {
    op_class_t cls;
  } rom_state_t;

  rom_state_t s_q;
  rom_state_t s_d;

  function automatic op_class_t lookup(input logic [7:0] op);
    op_class_t c;
    logic [3:0] row;
    logic [3:0] col;
    c.legal = 1'b1;
    c.mode = AM_INH;
    row = op[7:4];
    col = op[3:0];
    case (row)
      ROW_BIT_REL: c.mode = AM_BIT_REL;
      ROW_BIT: c.mode = AM_BIT;
      ROW_REL: c.mode = AM_REL;
      ROW_DIR_RMW, ROW_DIR_S: c.mode = AM_DIR_S;
      ROW_IDXS_RMW, ROW_IDX_S: c.mode = AM_IDX_S;
      ROW_IDX0_RMW, ROW_IDX0: c.mode = AM_IDX0;
      ROW_IMM: c.mode = AM_IMM;
      ROW_DIR_L: c.mode = AM_DIR_L;
      ROW_IDX_L: c.mode = AM_IDX_L;
      default: c.mode = AM_INH;
    endcase
    if (op == OP_REL_CALL) begin
      c.mode = AM_REL;
    end
    // Holes in the read-modify-write rows have no instruction behind them
    if (row >= ROW_DIR_RMW && row <= ROW_IDX0_RMW && op != OP_MUL &&
        (col == COL_HOLE_A || col == COL_HOLE_B || col == COL_HOLE_C || col == COL_HOLE_D)) begin
      c.legal = 1'b0; // RULE22
    end
    if (op == OP_BAD_IMM_ST || op == OP_BAD_IMM_JP) begin
      c.legal = 1'b0; // RULE20
    end
    return c;
  endfunction

  always_comb begin
    s_d = s_q;
    if (rd_en) begin
      s_d.cls = lookup(opcode);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign class_out = s_q.cls;

endmodule

//--- design/insn_decoder.sv
// Instruction fetch, prefix handling, effective-address formation and illegal-opcode detection
// Functional notes
// RULE1 - Immediate: opcode then one operand byte
// RULE2 - Short direct: one address byte, page zero
// RULE3 - Long direct: two address bytes, full space
// RULE4 - Indexed address is unsigned index plus offset
// RULE5 - No-offset indexed: no byte, index is address
// RULE6 - Short indexed: one offset byte, up to 1FE
// RULE7 - Long indexed: two offset bytes, full space
// RULE8 - Indirect: byte after opcode addresses a pointer
// RULE9 - Short indirect: byte pointer, page zero
// RULE10 - Long indirect: byte address, word pointer
// RULE11 - Indirect indexed: pointer plus index, unsigned
// RULE12 - Short indirect indexed: byte pointer, up to 1FE
// RULE13 - Relative: PC plus signed 8-bit offset
// RULE14 - Relative direct: offset follows the opcode
// RULE15 - Relative indirect: offset read from memory
// RULE16 - One to four bytes: prefix, opcode, 0-2
// RULE17 - Prefix 90 swaps X for Y
// RULE18 - Prefix 92 selects the indirect forms
// RULE19 - Prefix 91 selects Y indirect indexed
// RULE20 - Unknown opcode byte requests a reset
// RULE21 - Unauthorised prefix combination never requests reset
// RULE22 - Opcode table covers the whole instruction set
// RULE23 - Relative base is the following instruction
// RULE24 - Illegal opcode: one-cycle reset request, no completion
`timescale 1ns/10ps
module insn_decoder (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] x_index,
  input wire logic [7:0] y_index,
  output logic pm_rd,
  output logic [15:0] pm_addr,
  input wire logic [7:0] pm_data,
  input wire logic pm_ack,
  output logic dm_rd,
  output logic [15:0] dm_addr,
  input wire logic [7:0] dm_data,
  input wire logic dm_ack,
  output logic dec_valid,
  input wire logic dec_ready,
  input wire logic pc_load,
  input wire logic [15:0] pc_new,
  output decode_pkg::am_t dec_mode,
  output logic [7:0] dec_opcode,
  output logic [7:0] dec_prefix,
  output logic dec_use_y,
  output logic [2:0] dec_len,
  output logic [7:0] dec_operand,
  output logic [15:0] dec_ea,
  output logic [15:0] dec_target,
  output logic illegal_rst_req
);
  import decode_pkg::*;

  typedef enum logic [3:0] {
    ST_FETCH, ST_CLASS, ST_BYTE1, ST_BYTE2, ST_PTR_HI, ST_PTR_LO, ST_CALC, ST_OUT, ST_ILLEGAL
  } fsm_t;

  typedef struct packed {
    fsm_t st;
    logic [15:0] pc;
    logic [7:0] pfx;
    logic [7:0] op;
    am_t mode;
    logic use_y;
    logic [1:0] left;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [15:0] ptr;
    logic [2:0] len;
    logic [15:0] ea;
    logic [15:0] target;
    logic [7:0] operand;
    logic pm_rd;
    logic [15:0] pm_addr;
    logic dm_rd;
    logic [15:0] dm_addr;
    logic valid;
    logic ill;
  } dec_state_t;

  dec_state_t s_q;
  dec_state_t s_d;
  op_class_t cls;
  logic rom_rd;

  // Only a first prefix is peeled off; a second one is looked up as an opcode
  assign rom_rd = (s_q.st == ST_FETCH) && pm_ack && !(is_prefix(pm_data) && s_q.pfx == PFX_NONE);

  opcode_mode_rom u_rom (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .rd_en(rom_rd),
    .opcode(pm_data),
    .class_out(cls)
  );

  function automatic logic is_prefix(input logic [7:0] b);
    return b == PFX_Y_SWAP || b == PFX_IND_Y || b == PFX_IND;
  endfunction

  // Unmatched prefix/mode pairs fall through unchanged rather than faulting
  function automatic am_t apply_prefix(input logic [7:0] pfx, input am_t am);
    am_t m;
    m = am;
    if (pfx == PFX_IND) begin
      case (am)
        AM_DIR_S: m = AM_IND_S; // RULE18
        AM_DIR_L: m = AM_IND_L; // RULE18
        AM_BIT: m = AM_BIT_IND; // RULE18
        AM_BIT_REL: m = AM_BIT_IND_REL; // RULE18
        AM_REL: m = AM_REL_IND; // RULE18
        AM_IDX_S: m = AM_IIDX_S; // RULE18
        AM_IDX_L: m = AM_IIDX_L; // RULE18
        default: m = am; // RULE21
      endcase
    end else if (pfx == PFX_IND_Y) begin
      case (am)
        AM_IDX_S: m = AM_IIDX_S; // RULE19
        AM_IDX_L: m = AM_IIDX_L; // RULE19
        default: m = am; // RULE21
      endcase
    end
    return m;
  endfunction

  function automatic logic y_select(input logic [7:0] pfx, input am_t am);
    logic y;
    y = 1'b0;
    if (pfx == PFX_Y_SWAP) begin
      y = am inside {AM_INH, AM_IMM, AM_DIR_S, AM_DIR_L, AM_IDX0, AM_IDX_S, AM_IDX_L}; // RULE17
    end else if (pfx == PFX_IND_Y) begin
      y = am inside {AM_IDX_S, AM_IDX_L}; // RULE19
    end
    return y;
  endfunction

  // Bytes that follow the opcode in each final mode
  function automatic logic [1:0] extra_bytes(input am_t am);
    case (am)
      AM_INH, AM_IDX0: return BYTES_NONE; // RULE5
      AM_DIR_L, AM_IDX_L, AM_BIT_REL, AM_BIT_IND_REL: return BYTES_TWO; // RULE3 RULE7 RULE16
      default: return BYTES_ONE; // RULE1 RULE2 RULE6 RULE10 RULE14
    endcase
  endfunction

  function automatic logic needs_ptr(input am_t am);
    return am inside {AM_IND_S, AM_IND_L, AM_IIDX_S, AM_IIDX_L, AM_REL_IND, AM_BIT_IND, AM_BIT_IND_REL};
  endfunction

  function automatic logic word_ptr(input am_t am);
    return am inside {AM_IND_L, AM_IIDX_L};
  endfunction

  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] ofs);
    return pc + {{8{ofs[7]}}, ofs}; // RULE13
  endfunction

  always_comb begin
    logic [15:0] idx;
    logic [15:0] page0;
    am_t fm;
    s_d = s_q;
    idx = {ZERO_BYTE, s_q.use_y ? y_index : x_index};
    page0 = {ZERO_BYTE, s_q.b1};
    fm = apply_prefix(s_q.pfx, cls.mode);
    s_d.ill = 1'b0;
    case (s_q.st)
      ST_FETCH: begin
        s_d.pm_rd = 1'b1;
        s_d.pm_addr = s_q.pc;
        if (pm_ack) begin
          s_d.pc = s_q.pc + PC_STEP;
          s_d.pm_addr = s_q.pc + PC_STEP;
          s_d.len = s_q.len + LEN_STEP;
          // A second prefix is taken as an opcode byte, never as a fault
          if (is_prefix(pm_data) && s_q.pfx == PFX_NONE) begin
            s_d.pfx = pm_data; // RULE16
          end else begin
            s_d.op = pm_data;
            s_d.pm_rd = 1'b0;
            s_d.st = ST_CLASS;
          end
        end
      end
      ST_CLASS: begin
        if (!cls.legal) begin
          s_d.ill = 1'b1; // RULE20 RULE24
          s_d.st = ST_ILLEGAL;
        end else begin
          s_d.mode = fm;
          s_d.use_y = y_select(s_q.pfx, cls.mode);
          s_d.left = extra_bytes(fm);
          if (extra_bytes(fm) == BYTES_NONE) begin
            s_d.st = ST_CALC;
          end else begin
            s_d.pm_rd = 1'b1;
            s_d.pm_addr = s_q.pc;
            s_d.st = ST_BYTE1;
          end
        end
      end
      ST_BYTE1, ST_BYTE2: begin
        if (pm_ack) begin
          s_d.pc = s_q.pc + PC_STEP;
          s_d.pm_addr = s_q.pc + PC_STEP;
          s_d.len = s_q.len + LEN_STEP;
          s_d.left = s_q.left - BYTES_ONE;
          if (s_q.st == ST_BYTE1) begin
            s_d.b1 = pm_data;
          end else begin
            s_d.b2 = pm_data;
          end
          if (s_q.left == BYTES_TWO) begin
            s_d.st = ST_BYTE2;
          end else begin
            s_d.pm_rd = 1'b0;
            if (needs_ptr(s_q.mode)) begin
              s_d.dm_rd = 1'b1;
              s_d.dm_addr = (s_q.st == ST_BYTE1) ? {ZERO_BYTE, pm_data} : page0; // RULE8
              s_d.st = word_ptr(s_q.mode) ? ST_PTR_HI : ST_PTR_LO;
            end else begin
              s_d.st = ST_CALC;
            end
          end
        end
      end
      ST_PTR_HI: begin
        if (dm_ack) begin
          s_d.ptr = {dm_data, ZERO_BYTE}; // RULE10
          s_d.dm_addr = s_q.dm_addr + PC_STEP;
          s_d.st = ST_PTR_LO;
        end
      end
      ST_PTR_LO: begin
        if (dm_ack) begin
          s_d.ptr = {s_q.ptr[15:8], dm_data}; // RULE9 RULE15
          s_d.dm_rd = 1'b0;
          s_d.st = ST_CALC;
        end
      end
      ST_CALC: begin
        s_d.ea = '0;
        s_d.target = '0;
        s_d.operand = ZERO_BYTE;
        case (s_q.mode)
          AM_IMM: s_d.operand = s_q.b1; // RULE1
          AM_DIR_S, AM_BIT: s_d.ea = page0; // RULE2
          AM_DIR_L: s_d.ea = {s_q.b1, s_q.b2}; // RULE3
          AM_IDX0: s_d.ea = idx; // RULE5
          AM_IDX_S: s_d.ea = idx + page0; // RULE4 RULE6
          AM_IDX_L: s_d.ea = idx + {s_q.b1, s_q.b2}; // RULE4 RULE7
          AM_IND_S, AM_IND_L, AM_BIT_IND: s_d.ea = s_q.ptr; // RULE8 RULE9 RULE10
          AM_IIDX_S, AM_IIDX_L: s_d.ea = idx + s_q.ptr; // RULE11 RULE12
          // PC already points past the whole instruction here
          AM_REL: s_d.target = rel_target(s_q.pc, s_q.b1); // RULE14 RULE23
          AM_REL_IND: s_d.target = rel_target(s_q.pc, s_q.ptr[7:0]); // RULE15 RULE23
          AM_BIT_REL: begin
            s_d.ea = page0;
            s_d.target = rel_target(s_q.pc, s_q.b2); // RULE23
          end
          AM_BIT_IND_REL: begin
            s_d.ea = s_q.ptr;
            s_d.target = rel_target(s_q.pc, s_q.b2); // RULE23
          end
          default: s_d.ea = '0;
        endcase
        s_d.valid = 1'b1;
        s_d.st = ST_OUT;
      end
      ST_OUT: begin
        if (dec_ready) begin
          s_d.valid = 1'b0;
          s_d.pfx = PFX_NONE;
          s_d.len = LEN_NONE;
          s_d.ptr = '0;
          if (pc_load) begin
            s_d.pc = pc_new;
          end
          s_d.st = ST_FETCH;
        end
      end
      ST_ILLEGAL: begin
        // Wait here for the reset controller; nothing is handed to execution
        s_d.st = ST_ILLEGAL; // RULE24
      end
      default: s_d.st = ST_FETCH;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= ST_FETCH;
      s_q.pc <= BOOT_PC;
      s_q.pfx <= PFX_NONE;
      s_q.mode <= AM_INH;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign pm_rd = s_q.pm_rd;
  assign pm_addr = s_q.pm_addr;
  assign dm_rd = s_q.dm_rd;
  assign dm_addr = s_q.dm_addr;
  assign dec_valid = s_q.valid;
  assign dec_mode = s_q.mode;
  assign dec_opcode = s_q.op;
  assign dec_prefix = s_q.pfx;
  assign dec_use_y = s_q.use_y;
  assign dec_len = s_q.len;
  assign dec_operand = s_q.operand;
  assign dec_ea = s_q.ea;
  assign dec_target = s_q.target;
  assign illegal_rst_req = s_q.ill;

endmodule

//--- sim/mem_port_model.sv
// Byte-wide memory model answering one read request port
`timescale 1ns/10ps
module mem_port_model (
  input wire logic ref_clk,
  input wire logic rd,
  input wire logic [15:0] addr,
  input wire logic [1:0] wait_cycles,
  output logic [7:0] data,
  output logic ack
);
  logic [7:0] mem [0:65535];
  logic [1:0] cnt_q;
  initial begin
    ack = 1'b0;
    data = 8'h00;
    cnt_q = 2'h0;
  end
  // One-cycle ack; a held request waits afresh before each byte
  always @(posedge ref_clk) begin
    if (rd && !ack && cnt_q == wait_cycles) begin
      ack <= 1'b1;
      data <= mem[addr];
      cnt_q <= 2'h0;
    end else begin
      ack <= 1'b0;
      // Released bus toggles so a stale byte never looks valid
      data <= ~data;
      if (rd && !ack) begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end
endmodule

//--- sim/insn_decoder_assertions.sv
// Port-level checks for the instruction decoder
`timescale 1ns/10ps
module insn_decoder_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic pm_rd,
  input wire logic pm_ack,
  input wire logic [15:0] pm_addr,
  input wire logic dec_valid,
  input wire logic dec_ready,
  input decode_pkg::am_t dec_mode,
  input wire logic [2:0] dec_len,
  input wire logic [15:0] dec_ea,
  input wire logic dm_rd,
  input wire logic [15:0] dm_addr,
  input wire logic illegal_rst_req
);
  import decode_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_rst_pulse;
    illegal_rst_req && clk_en |=> !illegal_rst_req;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
  property p_stall;
    illegal_rst_req |=> (!dec_valid && !pm_rd) [*6];
  endproperty
  a_stall: assert property (p_stall) else $error("decoder went on after illegal opcode");
  property p_stand;
    dec_valid && !dec_ready |=> dec_valid && $stable(dec_ea) && $stable(dec_mode) && $stable(dec_len);
  endproperty
  a_stand: assert property (p_stand) else $error("decode result moved before acceptance");
  property p_accept;
    dec_valid && dec_ready && clk_en |=> !dec_valid;
  endproperty
  a_accept: assert property (p_accept) else $error("valid stayed after acceptance");
  property p_imm_len;
    dec_valid && dec_mode == AM_IMM |-> dec_len inside {3'h2, 3'h3};
  endproperty
  a_imm_len: assert property (p_imm_len) else $error("immediate length wrong");
  property p_noofs;
    dec_valid && dec_mode == AM_IDX0 |-> dec_ea[15:8] == 8'h00 && dec_len inside {3'h1, 3'h2};
  endproperty
  a_noofs: assert property (p_noofs) else $error("no-offset indexed out of page");
  property p_short;
    dec_valid && dec_mode inside {AM_IDX_S, AM_IIDX_S} |-> dec_ea <= 16'h01fe;
  endproperty
  a_short: assert property (p_short) else $error("short indexed address too high");
  property p_fetch_step;
    pm_rd && pm_ack && clk_en |=> pm_addr == $past(pm_addr) + 16'h0001;
  endproperty
  a_fetch_step: assert property (p_fetch_step) else $error("fetch address did not step");
  property p_ptr_page;
    $rose(dm_rd) |-> dm_addr[15:8] == 8'h00;
  endproperty
  a_ptr_page: assert property (p_ptr_page) else $error("pointer address beyond page zero");
endmodule
bind insn_decoder insn_decoder_checker chk (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .pm_rd(pm_rd),
  .pm_ack(pm_ack), .pm_addr(pm_addr), .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_mode(dec_mode),
  .dec_len(dec_len), .dec_ea(dec_ea), .dm_rd(dm_rd), .dm_addr(dm_addr), .illegal_rst_req(illegal_rst_req));

//--- sim/cpu_addressing_prebyte_decoder_bench.sv
// Self-checking bench for the prefix-aware instruction decoder
`timescale 1ns/10ps
module cpu_addressing_prebyte_decoder_bench;
  import decode_pkg::*;
  logic ref_clk, rst, clk_en, dec_ready, pc_load, pm_rd, pm_ack, dm_rd, dm_ack;
  logic dec_valid, dec_use_y, illegal_rst_req;
  logic [7:0] x_index, y_index, pm_data, dm_data, dec_opcode, dec_prefix, dec_operand;
  logic [15:0] pm_addr, dm_addr, pc_new, dec_ea, dec_target, pc, exp_target;
  logic [2:0] dec_len;
  logic [1:0] slow;
  am_t dec_mode;
  int failures = 0;
  int comparisons = 0;
  int ill_cnt = 0;
  insn_decoder uut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .x_index(x_index), .y_index(y_index),
    .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data), .pm_ack(pm_ack), .dm_rd(dm_rd), .dm_addr(dm_addr),
    .dm_data(dm_data), .dm_ack(dm_ack), .dec_valid(dec_valid), .dec_ready(dec_ready), .pc_load(pc_load),
    .pc_new(pc_new), .dec_mode(dec_mode), .dec_opcode(dec_opcode), .dec_prefix(dec_prefix),
    .dec_use_y(dec_use_y), .dec_len(dec_len), .dec_operand(dec_operand), .dec_ea(dec_ea),
    .dec_target(dec_target), .illegal_rst_req(illegal_rst_req));
  mem_port_model pmem (.ref_clk(ref_clk), .rd(pm_rd), .addr(pm_addr), .wait_cycles(slow), .data(pm_data),
    .ack(pm_ack));
  mem_port_model dmem (.ref_clk(ref_clk), .rd(dm_rd), .addr(dm_addr), .wait_cycles(slow), .data(dm_data),
    .ack(dm_ack));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (illegal_rst_req === 1'b1) ill_cnt++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Places one instruction at pc, checks its decode, optionally stalls, then accepts it
  task automatic run(input logic [31:0] code, input int n, input am_t m, input logic [15:0] v,
    input logic y, input int hold);
    int k;
    logic [7:0] pb;
    pb = (code[31:24] inside {8'h90, 8'h91, 8'h92}) ? code[31:24] : 8'h00;
    for (k = 0; k < n; k++) pmem.mem[pc + 16'(k)] = code[31 - 8 * k -: 8];
    k = 0;
    while (dec_valid !== 1'b1 && k < 200) begin
      @(negedge ref_clk);
      k++;
    end
    chk(16'(dec_mode), 16'(m));
    chk({13'h0, dec_len}, 16'(n));
    chk({15'h0, dec_use_y}, {15'h0, y});
    chk({8'h00, dec_prefix}, {8'h00, pb});
    chk({8'h00, dec_opcode}, {8'h00, (pb == 8'h00) ? code[31:24] : code[23:16]});
    if (m == AM_IMM) chk({8'h00, dec_operand}, v);
    else if (m == AM_REL || m == AM_REL_IND) chk(dec_target, v);
    else chk(dec_ea, v);
    if (m == AM_BIT_REL || m == AM_BIT_IND_REL) chk(dec_target, exp_target);
    if (hold > 0) begin
      clk_en = 1'b0;
      cycles(hold);
      clk_en = 1'b1;
      cycles(hold);
      chk({15'h0, dec_valid}, 16'h0001);
      chk(dec_ea, v);
    end
    dec_ready = 1'b1;
    @(negedge ref_clk);
    dec_ready = 1'b0;
    pc = pc_load ? pc_new : pc + 16'(n);
  endtask
  task automatic t_direct;
    run(32'ha6550000, 2, AM_IMM, 16'h0055, 1'b0, 0);
    run(32'h90a67700, 3, AM_IMM, 16'h0077, 1'b1, 0);
    run(32'hb6ff0000, 2, AM_DIR_S, 16'h00ff, 1'b0, 0);
    run(32'hc6123400, 3, AM_DIR_L, 16'h1234, 1'b0, 0);
    $display("direct and immediate test done");
  endtask
  task automatic t_indexed;
    run(32'hf6000000, 1, AM_IDX0, 16'h00ff, 1'b0, 0);
    run(32'h90f60000, 2, AM_IDX0, 16'h0080, 1'b1, 0);
    run(32'he6ff0000, 2, AM_IDX_S, 16'h01fe, 1'b0, 0);
    run(32'hd6120000, 3, AM_IDX_L, 16'h12ff, 1'b0, 0);
    $display("indexed test done");
  endtask
  task automatic t_indirect;
    dmem.mem[16'h0010] = 8'hff;
    dmem.mem[16'h0020] = 8'hab;
    dmem.mem[16'h0021] = 8'hcd;
    run(32'h92b61000, 3, AM_IND_S, 16'h00ff, 1'b0, 0);
    run(32'h92c62000, 3, AM_IND_L, 16'habcd, 1'b0, 0);
    run(32'h92e61000, 3, AM_IIDX_S, 16'h01fe, 1'b0, 0);
    run(32'h92d62000, 3, AM_IIDX_L, 16'haccc, 1'b0, 0);
    run(32'h91e61000, 3, AM_IIDX_S, 16'h017f, 1'b1, 0);
    $display("indirect test done");
  endtask
  task automatic t_relative;
    dmem.mem[16'h0030] = 8'hfe;
    run(32'h26800000, 2, AM_REL, pc - 16'h007e, 1'b0, 0);
    run(32'had7f0000, 2, AM_REL, pc + 16'h0081, 1'b0, 0);
    run(32'h92263000, 3, AM_REL_IND, pc + 16'h0001, 1'b0, 0);
    $display("relative test done");
  endtask
  task automatic t_bit_modes;
    dmem.mem[16'h0040] = 8'h44;
    exp_target = pc + 16'h0008;
    run(32'h02400500, 3, AM_BIT_REL, 16'h0040, 1'b0, 0);
    exp_target = pc + 16'h0009;
    run(32'h92024005, 4, AM_BIT_IND_REL, 16'h0044, 1'b0, 0);
    run(32'h12400000, 2, AM_BIT, 16'h0040, 1'b0, 0);
    run(32'h92124000, 3, AM_BIT_IND, 16'h0044, 1'b0, 0);
    run(32'h92910000, 2, AM_INH, 16'h0000, 1'b0, 0);
    $display("bit and double prefix test done");
  endtask
  task automatic t_prefix_stall;
    run(32'h91a65500, 3, AM_IMM, 16'h0055, 1'b0, 0);
    chk(16'(ill_cnt), 16'h0000);
    slow = 2'h3;
    pc_load = 1'b1;
    pc_new = 16'h4000;
    run(32'hc6beef00, 3, AM_DIR_L, 16'hbeef, 1'b0, 3);
    pc_load = 1'b0;
    run(32'h92c62000, 3, AM_IND_L, 16'habcd, 1'b0, 0);
    slow = 2'h0;
    $display("prefix and stall test done");
  endtask
  task automatic t_illegal;
    logic [7:0] bad [3] = '{8'h31, 8'ha7, 8'hac};
    for (int i = 0; i < 3; i++) begin
      pmem.mem[pc] = bad[i];
      cycles(20);
      chk(16'(ill_cnt), 16'(i + 1));
      chk({15'h0, dec_valid}, 16'h0000);
      rst = 1'b1;
      cycles(2);
      rst = 1'b0;
      pc = 16'h0000;
    end
    run(32'ha6420000, 2, AM_IMM, 16'h0042, 1'b0, 0);
    $display("illegal opcode test done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    dec_ready = 1'b0;
    pc_load = 1'b0;
    pc_new = 16'h0000;
    x_index = 8'hff;
    y_index = 8'h80;
    slow = 2'h0;
    pc = 16'h0000;
    cycles(4);
    rst = 1'b0;
    t_direct();
    t_indexed();
    t_indirect();
    t_relative();
    t_bit_modes();
    t_prefix_stall();
    t_illegal();
    tally_and_finish();
  end
endmodule
